/* hw/pdma_cfg.svh */
/*
  Address map, fields and reset values of the DMA.
  Included by the bus front end and the top; definitions only.
*/
`ifndef PDMA_CFG_SVH
`define PDMA_CFG_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PDMA_NCH        8
`define PDMA_SRC_N      128

// ----------------------------------------
// Address map
// ----------------------------------------
`define PDMA_CH_HI      7
`define PDMA_CH_LO      5
`define PDMA_REG_HI     4
`define PDMA_REG_LO     0
`define PDMA_GLOB_BIT   8
`define PDMA_TOP_HI     11
`define PDMA_TOP_LO     9
`define PDMA_OFF_CON    5'h00
`define PDMA_OFF_REQ    5'h04
`define PDMA_OFF_STA    5'h08
`define PDMA_OFF_STB    5'h0C
`define PDMA_OFF_PAD    5'h10
`define PDMA_OFF_CNT    5'h14
`define PDMA_OFF_CS0    5'h00
`define PDMA_OFF_CS1    5'h04

// ----------------------------------------
// Fields
// ----------------------------------------
`define PDMA_CON_CHEN   15
`define PDMA_CON_SIZE   14
`define PDMA_CON_DIR    13
`define PDMA_CON_HALF   12
`define PDMA_CON_NULLW  11
`define PDMA_CON_AMHI   5
`define PDMA_CON_AMLO   4
`define PDMA_MODE_ONE   0
`define PDMA_MODE_PP    1
`define PDMA_CON_MASK   16'hF833
`define PDMA_REQ_FORCE  15
`define PDMA_REQ_MASK   16'h807F
`define PDMA_CNT_MASK   16'h03FF
`define PDMA_AM_POSTINC 2'h0
`define PDMA_AM_NOINC   2'h1
`define PDMA_RST16      16'h0000
`define PDMA_LST_NONE   4'hF
`define PDMA_STEP_BYTE  16'h0001
`define PDMA_STEP_WORD  16'h0002
`define PDMA_RESP_OKAY  2'h0
`define PDMA_RESP_SLV   2'h2

`endif

/* hw/pdma_pkg.sv */
/*
  Types and helpers of the DMA.
  No assumptions beyond the configuration header.
*/
package pdma_pkg;

  typedef logic [15:0] pdma_word_t;
  typedef logic [9:0]  pdma_cnt_t;

  typedef enum logic [3:0] {
    PDMA_S_IDLE = 4'h1,
    PDMA_S_RD   = 4'h2,
    PDMA_S_WR   = 4'h4,
    PDMA_S_FIN  = 4'h8
  } pdma_state_t;

  // Byte-lane merge of implemented bits
  function automatic pdma_word_t pdma_merge(pdma_word_t old, pdma_word_t nw,
                                            logic [1:0] strb, pdma_word_t mask);
    pdma_word_t m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~m) | (nw & m);
  endfunction : pdma_merge

endpackage : pdma_pkg

/* hw/pdma_arb.sv */
/*
  Fixed-priority pick, lowest channel index first.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
module pdma_arb #(
  parameter int N = 8
) (
  // Requests
  input  wire logic [N-1:0]         req,
  // Pick
  output logic                      any,
  output logic [$clog2(N)-1:0]      idx
);
  localparam int IW = $clog2(N);

  always_comb
  begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = IW'(i); // RQ25
      end
    end
  end

endmodule : pdma_arb

/* hw/pdma_axil.sv */
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes the parent decodes addresses combinationally.
*/
`timescale 1ns/1ns
`include "pdma_cfg.svh"
module pdma_axil #(
  parameter int AW = 12
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite slave
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Register side
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_err,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_err
);
  logic aw_got;
  logic w_got;

  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk)
  begin : aw_ch
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b0;
      wr_addr       <= '0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && !aw_got && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got  <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      else if (wr_en)
        aw_got <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin : w_ch
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b0;
      wr_data      <= '0;
      wr_strb      <= '0;
    end
    else
    begin
      s_axi_wready <= s_axi_wvalid && !w_got && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got   <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      else if (wr_en)
        w_got <= 1'b0;
    end
  end

  // Guard on wr_en keeps a held pair from firing twice
  always_ff @(posedge aclk)
  begin : b_ch
    if (!aresetn)
    begin
      wr_en        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PDMA_RESP_OKAY;
    end
    else
    begin
      wr_en <= aw_got && w_got && !s_axi_bvalid && !wr_en;
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `PDMA_RESP_SLV : `PDMA_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin : r_ch
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `PDMA_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? `PDMA_RESP_SLV : `PDMA_RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : pdma_axil

/* hw/pdma_top.sv */
/*
  Eight-channel peripheral DMA engine with its own transfer bus.
  Assumes both buses return read data a cycle after re.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
// Operation
// [RQ1] Eight channels, each with private registers
// [RQ2] Per-channel direction: RAM to peripheral or back
// [RQ3] Transfers use own bus, not CPU path
// [RQ4] Seven-bit source code selects triggering request
// [RQ5] Serial transmit/receive codes pair with their addresses
// [RQ6] SPI done code shares one data address
// [RQ7] Audio right and left codes with addresses
// [RQ8] Post-increment, fixed, or peripheral-indirect RAM addressing
// [RQ9] Interrupt at block end, or at half
// [RQ10] Byte or word per transfer
// [RQ11] Fixed-priority arbitration among requesting channels
// [RQ12] Start on peripheral request or software force
// [RQ13] One-shot stops; continuous restarts the block
// [RQ14] Ping-pong swaps start addresses per block
// [RQ15] Six per-channel registers, count ten bits
// [RQ16] Shared RAM and peripheral write-collision flags
// [RQ17] Shared status: active channel, ping-pong buffers
// [RQ18] Start-address reads return live pointer
// [RQ19] Other registers are plain storage
// [RQ20] Only interrupt request pulses leave the block
// [RQ21] Software keeps buffers inside DMA RAM
// [RQ22] Force bit cleared only by hardware
// [RQ23] Direction one: RAM to peripheral
// [RQ24] Two-bit mode: continuous/one-shot, ping-pong
// [RQ25] Channel zero highest, one grant per cycle
// [RQ26] Block ends after count plus one transfers
`timescale 1ns/1ns
`include "pdma_cfg.svh"
module pdma_top #(
  parameter int AW  = 12,
  parameter int NCH = `PDMA_NCH,
  parameter int NSRC = `PDMA_SRC_N
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite slave
  input  wire logic [AW-1:0]      s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [AW-1:0]      s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Request sources and peripheral-supplied address
  input  wire logic [NSRC-1:0]    irq_src,
  input  wire pdma_pkg::pdma_word_t pind_addr,
  // Peripheral side of the transfer bus
  output pdma_pkg::pdma_word_t    per_addr,
  output pdma_pkg::pdma_word_t    per_wdata,
  output logic                    per_we,
  output logic                    per_re,
  input  wire pdma_pkg::pdma_word_t per_rdata,
  // RAM side of the transfer bus
  output pdma_pkg::pdma_word_t    ram_addr,
  output pdma_pkg::pdma_word_t    ram_wdata,
  output logic                    ram_we,
  output logic                    ram_re,
  input  wire pdma_pkg::pdma_word_t ram_rdata,
  output logic                    xfer_byte,
  // CPU writes watched for collisions
  input  wire logic               cpu_ram_we,
  input  wire pdma_pkg::pdma_word_t cpu_ram_addr,
  input  wire logic               cpu_per_we,
  input  wire pdma_pkg::pdma_word_t cpu_per_addr,
  // Interrupt requests to the interrupt controller
  output logic [NCH-1:0]          ch_irq
);
  import pdma_pkg::*;
  localparam int CW = $clog2(NCH);
  localparam int SW = $clog2(NSRC);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          wr_err;
  logic [AW-1:0] rd_addr;
  logic [31:0]   rd_data;
  logic          rd_err;

  pdma_axil #(.AW(AW)) u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .wr_err(wr_err),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_err(rd_err)
  );

  function automatic logic mapped(logic [AW-1:0] a);
    logic [4:0] r;
    r = a[`PDMA_REG_HI:`PDMA_REG_LO];
    if (a[`PDMA_TOP_HI:`PDMA_TOP_LO] != '0)
      return 1'b0;
    if (a[`PDMA_GLOB_BIT])
      return a[`PDMA_CH_HI:`PDMA_CH_LO] == '0 && (r == `PDMA_OFF_CS0 || r == `PDMA_OFF_CS1);
    return r[1:0] == 2'h0 && r <= `PDMA_OFF_CNT;
  endfunction : mapped

  // ----------------------------------------
  // Channel state
  // ----------------------------------------
  pdma_word_t  con_q [NCH];
  pdma_word_t  req_q [NCH];
  pdma_word_t  sta_q [NCH];
  pdma_word_t  stb_q [NCH];
  pdma_word_t  pad_q [NCH];
  pdma_word_t  cnt_q [NCH];
  pdma_word_t  ptr_q [NCH];
  pdma_cnt_t   done_q [NCH];
  logic [NCH-1:0] ppst_q;
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] xwcol_q;
  logic [NCH-1:0] pwcol_q;
  logic [3:0]     lstch_q;
  pdma_state_t    state_q;
  logic [CW-1:0]  cur_q;

  logic [CW-1:0] wch;
  logic [4:0]    wreg;
  logic          wloc;
  logic          any;
  logic [CW-1:0] gidx;
  logic [NCH-1:0] gnt;
  logic [NCH-1:0] new_req;
  logic          fin;
  logic          last;
  logic          half;
  logic          pp_next;
  pdma_word_t    step;
  pdma_word_t    cw;

  assign wch    = wr_addr[`PDMA_CH_HI:`PDMA_CH_LO];
  assign wreg   = wr_addr[`PDMA_REG_HI:`PDMA_REG_LO];
  assign wloc   = wr_en && mapped(wr_addr) && !wr_addr[`PDMA_GLOB_BIT];
  assign wr_err = !mapped(wr_addr);
  assign fin    = state_q == PDMA_S_FIN;
  assign cw     = con_q[cur_q];
  assign last   = done_q[cur_q] == cnt_q[cur_q][9:0]; // RQ26
  assign half   = done_q[cur_q] == {1'b0, cnt_q[cur_q][9:1]};
  assign step   = cw[`PDMA_CON_SIZE] ? `PDMA_STEP_BYTE : `PDMA_STEP_WORD; // RQ10
  assign pp_next = cw[`PDMA_MODE_PP] ? !ppst_q[cur_q] : ppst_q[cur_q]; // RQ14

  // RAM address for a channel under its addressing scheme
  function automatic pdma_word_t ram_ea(logic [CW-1:0] c);
    pdma_word_t base;
    base = ppst_q[c] ? stb_q[c] : sta_q[c];
    if (con_q[c][`PDMA_CON_AMHI:`PDMA_CON_AMLO] == `PDMA_AM_POSTINC ||
        con_q[c][`PDMA_CON_AMHI:`PDMA_CON_AMLO] == `PDMA_AM_NOINC)
      return ptr_q[c];
    return 16'(base + pind_addr); // RQ8
  endfunction : ram_ea

  // ----------------------------------------
  // Requests and arbitration
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      new_req[i] = con_q[i][`PDMA_CON_CHEN] &&
                   (irq_src[req_q[i][SW-1:0]] || // RQ4 RQ5 RQ6 RQ7 RQ12
                    (wloc && wreg == `PDMA_OFF_REQ && wch == CW'(i) &&
                     wr_strb[1] && wr_data[`PDMA_REQ_FORCE]));
      gnt[i] = state_q == PDMA_S_IDLE && any && gidx == CW'(i);
    end
  end

  pdma_arb #(.N(NCH)) u_arb (
    .req(pend_q),
    .any(any),
    .idx(gidx)
  );

  // Arrival beats same-cycle grant
  always_ff @(posedge aclk)
  begin : pending
    if (!aresetn)
      pend_q <= '0;
    else
      pend_q <= (pend_q & ~gnt) | new_req; // RQ11
  end

  // ----------------------------------------
  // Transfer engine on the dedicated bus
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin : engine
    if (!aresetn)
    begin
      state_q   <= PDMA_S_IDLE;
      cur_q     <= '0;
      lstch_q   <= `PDMA_LST_NONE;
      per_addr  <= `PDMA_RST16;
      per_wdata <= `PDMA_RST16;
      per_we    <= 1'b0;
      per_re    <= 1'b0;
      ram_addr  <= `PDMA_RST16;
      ram_wdata <= `PDMA_RST16;
      ram_we    <= 1'b0;
      ram_re    <= 1'b0;
      xfer_byte <= 1'b0;
    end
    else
    begin
      case (state_q)
        PDMA_S_IDLE:
          if (any)
          begin
            cur_q     <= gidx;
            lstch_q   <= 4'(gidx);
            xfer_byte <= con_q[gidx][`PDMA_CON_SIZE];
            if (con_q[gidx][`PDMA_CON_DIR]) // RQ2 RQ23
            begin
              ram_re   <= 1'b1;
              ram_addr <= ram_ea(gidx);
            end
            else
            begin
              per_re   <= 1'b1;
              per_addr <= pad_q[gidx];
            end
            state_q <= PDMA_S_RD;
          end
        PDMA_S_RD:
        begin
          ram_re  <= 1'b0;
          per_re  <= 1'b0;
          state_q <= PDMA_S_WR;
        end
        PDMA_S_WR:
        begin
          per_addr <= pad_q[cur_q];
          if (cw[`PDMA_CON_DIR]) // RQ3
          begin
            per_we    <= 1'b1;
            per_wdata <= cw[`PDMA_CON_SIZE] ? {8'h00, ram_rdata[7:0]} : ram_rdata;
          end
          else
          begin
            ram_we    <= 1'b1;
            ram_addr  <= ram_ea(cur_q);
            ram_wdata <= cw[`PDMA_CON_SIZE] ? {8'h00, per_rdata[7:0]} : per_rdata;
            // Null write keeps receive side clocking
            per_we    <= cw[`PDMA_CON_NULLW];
            per_wdata <= `PDMA_RST16;
          end
          state_q <= PDMA_S_FIN;
        end
        PDMA_S_FIN:
        begin
          ram_we  <= 1'b0;
          per_we  <= 1'b0;
          state_q <= PDMA_S_IDLE;
        end
        default:
          state_q <= PDMA_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Block progress and interrupt pulses
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin : progress
    if (!aresetn)
    begin
      ppst_q <= '0;
      ch_irq <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        ptr_q[i]  <= `PDMA_RST16;
        done_q[i] <= '0;
      end
    end
    else
    begin
      ch_irq <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        // Enable, or STA write while disabled, re-arms pointer
        if (wloc && wch == CW'(i) && wreg == `PDMA_OFF_CON && wr_strb[1] &&
            wr_data[`PDMA_CON_CHEN] && !con_q[i][`PDMA_CON_CHEN])
        begin
          ptr_q[i]  <= sta_q[i];
          ppst_q[i] <= 1'b0;
          done_q[i] <= '0;
        end
        else if (wloc && wch == CW'(i) && wreg == `PDMA_OFF_STA && !con_q[i][`PDMA_CON_CHEN])
          ptr_q[i] <= pdma_merge(sta_q[i], wr_data[15:0], wr_strb[1:0], 16'hFFFF);
      end
      if (fin)
      begin
        if (cw[`PDMA_CON_HALF] ? half : last) // RQ9 RQ20
          ch_irq[cur_q] <= 1'b1;
        if (last)
        begin
          done_q[cur_q] <= '0;
          ppst_q[cur_q] <= pp_next; // RQ14
          ptr_q[cur_q]  <= pp_next ? stb_q[cur_q] : sta_q[cur_q]; // RQ26
        end
        else
        begin
          done_q[cur_q] <= 10'(done_q[cur_q] + 10'h001);
          if (cw[`PDMA_CON_AMHI:`PDMA_CON_AMLO] == `PDMA_AM_POSTINC) // RQ8
            ptr_q[cur_q] <= 16'(ptr_q[cur_q] + step);
        end
      end
    end
  end

  // ----------------------------------------
  // Per-channel registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin : regs
    if (!aresetn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        con_q[i] <= `PDMA_RST16;
        req_q[i] <= `PDMA_RST16;
        sta_q[i] <= `PDMA_RST16;
        stb_q[i] <= `PDMA_RST16;
        pad_q[i] <= `PDMA_RST16;
        cnt_q[i] <= `PDMA_RST16;
      end
    end
    else
    begin
      if (wloc) // RQ1 RQ15 RQ19
      begin
        case (wreg)
          `PDMA_OFF_CON: con_q[wch] <= pdma_merge(con_q[wch], wr_data[15:0], wr_strb[1:0], `PDMA_CON_MASK);
          `PDMA_OFF_REQ: req_q[wch] <= pdma_merge(req_q[wch], wr_data[15:0], wr_strb[1:0], `PDMA_REQ_MASK)
                                       | (req_q[wch] & 16'h8000); // RQ22
          `PDMA_OFF_STA: sta_q[wch] <= pdma_merge(sta_q[wch], wr_data[15:0], wr_strb[1:0], 16'hFFFF);
          `PDMA_OFF_STB: stb_q[wch] <= pdma_merge(stb_q[wch], wr_data[15:0], wr_strb[1:0], 16'hFFFF);
          `PDMA_OFF_PAD: pad_q[wch] <= pdma_merge(pad_q[wch], wr_data[15:0], wr_strb[1:0], 16'hFFFF);
          `PDMA_OFF_CNT: cnt_q[wch] <= pdma_merge(cnt_q[wch], wr_data[15:0], wr_strb[1:0], `PDMA_CNT_MASK);
          default: ;
        endcase
      end
      if (fin)
      begin
        // Same-cycle force write survives
        if (!(wloc && wch == cur_q && wreg == `PDMA_OFF_REQ && wr_strb[1] && wr_data[`PDMA_REQ_FORCE]))
          req_q[cur_q][`PDMA_REQ_FORCE] <= 1'b0; // RQ22 RQ12
        if (last && cw[`PDMA_MODE_ONE] && (!cw[`PDMA_MODE_PP] || ppst_q[cur_q])) // RQ13 RQ24
          con_q[cur_q][`PDMA_CON_CHEN] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Collision flags, write one to clear
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin : collide
    if (!aresetn)
    begin
      xwcol_q <= '0;
      pwcol_q <= '0;
    end
    else
    begin
      if (wr_en && !wr_err && wr_addr[`PDMA_GLOB_BIT] && wr_addr[`PDMA_REG_HI:`PDMA_REG_LO] == `PDMA_OFF_CS0)
      begin
        xwcol_q <= xwcol_q & ~(wr_data[NCH-1:0] & {NCH{wr_strb[0]}});
        pwcol_q <= pwcol_q & ~(wr_data[NCH+7:8] & {NCH{wr_strb[1]}});
      end
      // Set wins over clear
      if (ram_we && cpu_ram_we && cpu_ram_addr == ram_addr)
        xwcol_q[cur_q] <= 1'b1; // RQ16
      if (per_we && cpu_per_we && cpu_per_addr == per_addr)
        pwcol_q[cur_q] <= 1'b1; // RQ16
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err  = !mapped(rd_addr);
    if (rd_addr[`PDMA_GLOB_BIT])
      rd_data[15:0] = rd_addr[`PDMA_REG_HI:`PDMA_REG_LO] == `PDMA_OFF_CS0 ?
                      {pwcol_q, xwcol_q} : {4'h0, lstch_q, ppst_q}; // RQ17
    else
      case (rd_addr[`PDMA_REG_HI:`PDMA_REG_LO])
        `PDMA_OFF_CON: rd_data[15:0] = con_q[rd_addr[`PDMA_CH_HI:`PDMA_CH_LO]];
        `PDMA_OFF_REQ: rd_data[15:0] = req_q[rd_addr[`PDMA_CH_HI:`PDMA_CH_LO]];
        `PDMA_OFF_STA,
        `PDMA_OFF_STB: rd_data[15:0] = ptr_q[rd_addr[`PDMA_CH_HI:`PDMA_CH_LO]]; // RQ18
        `PDMA_OFF_PAD: rd_data[15:0] = pad_q[rd_addr[`PDMA_CH_HI:`PDMA_CH_LO]];
        `PDMA_OFF_CNT: rd_data[15:0] = cnt_q[rd_addr[`PDMA_CH_HI:`PDMA_CH_LO]];
        default:       rd_data[15:0] = `PDMA_RST16;
      endcase
    if (rd_err)
      rd_data = 32'h0000_0000;
  end

endmodule : pdma_top

/* testbench/pdma_monitor.sv */
/*
  Checker on the DMA top ports.
  Assumes the bench top binds it.
*/
`timescale 1ns/1ns
module pdma_monitor (
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Register bus
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  // Transfer buses
  input wire logic                 per_re,
  input wire logic                 per_we,
  input wire pdma_pkg::pdma_word_t per_rdata,
  input wire pdma_pkg::pdma_word_t per_wdata,
  input wire logic                 ram_re,
  input wire logic                 ram_we,
  input wire pdma_pkg::pdma_word_t ram_rdata,
  input wire pdma_pkg::pdma_word_t ram_wdata,
  input wire logic                 xfer_byte,
  // Interrupt requests
  input wire logic [7:0]           ch_irq
);
  import pdma_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Transfer steps
  // ----------------------------------------
  sequence s_into_ram;
    ##2 ram_we ##1 !ram_we;
  endsequence
  sequence s_into_per;
    ##2 per_we ##1 !per_we;
  endsequence
  AST_PER_TO_RAM: assert property (per_re |-> s_into_ram)
    else $error("no RAM write");
  AST_RAM_TO_PER: assert property (ram_re |-> s_into_per)
    else $error("no peripheral write");
  AST_ONE_GRANT: assert property ((per_re | ram_re) |=> !(per_re | ram_re) [*3])
    else $error("grants too close");
  AST_RAM_DATA: assert property (ram_we && !xfer_byte |-> ram_wdata == $past(per_rdata))
    else $error("RAM data wrong");
  AST_PER_DATA: assert property (per_we && !ram_we && !xfer_byte |-> per_wdata == $past(ram_rdata))
    else $error("peripheral data wrong");
  AST_BYTE: assert property (ram_we && xfer_byte |-> ram_wdata == ($past(per_rdata) & 16'h00FF))
    else $error("byte high half set");
  AST_IRQ_CAUSE: assert property (|ch_irq |-> $past(ram_we | per_we) && $onehot(ch_irq))
    else $error("stray interrupt");
  AST_IRQ_PULSE: assert property (|ch_irq |=> ch_irq == 8'h00)
    else $error("interrupt too long");
  AST_RD_ANSWER: assert property ($rose(s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : pdma_monitor

/* testbench/pdma_partner.sv */
/*
  Peripheral and DMA RAM model, one-cycle read latency.
  Idle read lines toggle so stale data never matches.
*/
`timescale 1ns/1ns
module pdma_partner (
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Transfer buses
  input wire pdma_pkg::pdma_word_t per_addr,
  input wire logic                 per_re,
  output pdma_pkg::pdma_word_t     per_rdata,
  input wire pdma_pkg::pdma_word_t ram_addr,
  input wire logic                 ram_re,
  output pdma_pkg::pdma_word_t     ram_rdata
);
  import pdma_pkg::*;
  always_ff @(posedge aclk)
    per_rdata <= !aresetn ? 16'h0000 : per_re ? per_addr ^ 16'h5A5A : ~per_rdata;
  // Engine reaches only DMA RAM
  always_ff @(posedge aclk)
    ram_rdata <= !aresetn ? 16'h0000 : ram_re ? ram_addr ^ 16'h3C3C : ~ram_rdata;
endmodule : pdma_partner

/* testbench/pdma_tb_top.sv */
/*
  Register-level DMA bench.
  Assumes the partner answers both buses.
*/
`timescale 1ns/1ns
module pdma_tb_top;
  import pdma_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, per_we, per_re, ram_we, ram_re, xfer_byte;
  logic cpu_ram_we = 0, cpu_per_we = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [127:0] irq_src = 0;
  logic [7:0] ch_irq;
  pdma_word_t pind_addr = 0, cpu_ram_addr = 0, cpu_per_addr = 16'h0224, per_addr, per_wdata, per_rdata;
  pdma_word_t ram_addr, ram_wdata, ram_rdata, rv, la, ld, pa, pd;
  int err_count = 0, cmp_count = 0, irqs = 0;
  pdma_top i_dut (.*);
  pdma_partner i_far (.*);
  always #25 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (ram_we) {la, ld} <= {ram_addr, ram_wdata};
    if (per_we) {pa, pd} <= {per_addr, per_wdata};
    if (|ch_irq) irqs <= irqs + 1;
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 16'h0000, d, 4'h3};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {rv, rs} = {s_axi_rdata[15:0], s_axi_rresp};
    s_axi_rready <= 0;
  endtask : rd
  task automatic pulse(input int n);
    @(posedge aclk);
    irq_src[n] <= 1;
    @(posedge aclk);
    irq_src[n] <= 0;
    repeat (8) @(posedge aclk);
  endtask : pulse
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(12'h104); chk("activity", rv, 16'h0F00);
    rd(12'h200); chk("unmapped", {14'h0000, rs}, 16'h0002);
    wr(12'h034, 16'hFFFF); rd(12'h034); chk("count", rv, 16'h03FF);
    wr(12'h060, 16'h7FFF); rd(12'h060); chk("control", rv, 16'h7833);
    // Byte receive, two-transfer block
    wr(12'h010, 16'h0226); wr(12'h008, 16'h0100); wr(12'h014, 16'h0001);
    wr(12'h004, 16'h000B); wr(12'h000, 16'hC000);
    pulse(11);
    chk("ram addr", la, 16'h0100);
    chk("ram data", ld, 16'h007C);
    rd(12'h008); chk("live ptr", rv, 16'h0101);
    chk("early irq", irqs[15:0], 16'h0000);
    pulse(11);
    chk("ram addr2", la, 16'h0101);
    chk("block irq", irqs[15:0], 16'h0001);
    rd(12'h008); chk("reload", rv, 16'h0100);
    // Forced one-shot to transmitter
    wr(12'h050, 16'h0224); wr(12'h048, 16'h0200); wr(12'h054, 16'h0000);
    wr(12'h040, 16'hA001); wr(12'h044, 16'h800C);
    repeat (8) @(posedge aclk);
    chk("per addr", pa, 16'h0224);
    chk("per data", pd, 16'h3E3C);
    rd(12'h100); chk("collision", rv, 16'h0400);
    rd(12'h044); chk("force", rv, 16'h000C);
    rd(12'h040); chk("one-shot", rv, 16'h2001);
    chk("irq count", irqs[15:0], 16'h0002);
    results();
  end
  initial
  begin
    repeat (3000) @(posedge aclk);
    err_count++;
    results();
  end
endmodule : pdma_tb_top
bind pdma_top pdma_monitor i_mon (.*);
